// ### verilog/wdcs_pkg.sv
// package: offsets, bit positions, reset values and timing for the watchdog control/status block
package wdcs_pkg;
  localparam logic [7:0] WDCS_BOOT_SELECT_ADDR = 8'hd7;
  localparam logic [7:0] WDCS_CONTROL_STATUS_ADDR = 8'hd8;
  localparam logic [7:0] WDCS_TA_KEY_ADDR = 8'hc7; // timed access key register, arbitrary
  localparam logic [7:0] WDCS_TA_KEY1 = 8'haa;
  localparam logic [7:0] WDCS_TA_KEY2 = 8'h55;
  localparam int WDCS_TA_WINDOW_CYC = 4; // cycles the unlock stays open
  localparam int WDCS_BIT_LOADER = 0;
  localparam int WDCS_BIT_POR = 6;
  localparam int WDCS_BIT_IFLAG = 3;
  localparam int WDCS_BIT_RFLAG = 2;
  localparam int WDCS_BIT_RENA = 1;
  localparam int WDCS_BIT_RESTART = 0;
  localparam int WDCS_RESET_DELAY_CLK = 512;
  localparam logic [9:0] WDCS_DELAY_LAST = 10'h1ff; // 512 clocks minus one
  localparam logic [15:0] WDCS_RESTART_VECTOR = 16'h0000;
  typedef enum logic [1:0] {
    WDCS_TA_IDLE = 2'b00,
    WDCS_TA_HALF = 2'b01,
    WDCS_TA_OPEN = 2'b10
  } wdcs_ta_t;
endpackage : wdcs_pkg

// ### verilog/wdcs_timed_access.sv
// timed-access unlock sequencer: two key writes open a short write window
`timescale 1ns/1ps
module wdcs_timed_access (
  input wire logic clock,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic consume,
  output logic unlocked
);
  wdcs_pkg::wdcs_ta_t state_r;
  logic [2:0] cnt_r;
  logic key_wr;

  assign key_wr = wr_en && (wr_addr == wdcs_pkg::WDCS_TA_KEY_ADDR);
  assign unlocked = (state_r == wdcs_pkg::WDCS_TA_OPEN);

  // key sequence and window count; any protected write closes the window
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r <= wdcs_pkg::WDCS_TA_IDLE;
      cnt_r <= 3'h0;
    end else begin
      case (state_r)
        wdcs_pkg::WDCS_TA_IDLE: begin
          if (key_wr && wr_data == wdcs_pkg::WDCS_TA_KEY1) begin
            state_r <= wdcs_pkg::WDCS_TA_HALF;
          end
        end
        wdcs_pkg::WDCS_TA_HALF: begin
          if (key_wr && wr_data == wdcs_pkg::WDCS_TA_KEY2) begin
            state_r <= wdcs_pkg::WDCS_TA_OPEN;
            cnt_r <= 3'(wdcs_pkg::WDCS_TA_WINDOW_CYC - 1);
          end else begin
            state_r <= wdcs_pkg::WDCS_TA_IDLE;
          end
        end
        wdcs_pkg::WDCS_TA_OPEN: begin
          if (consume || cnt_r == 3'h0) begin
            state_r <= wdcs_pkg::WDCS_TA_IDLE;
          end else begin
            cnt_r <= cnt_r - 3'h1;
          end
        end
        default: state_r <= wdcs_pkg::WDCS_TA_IDLE;
      endcase
    end
  end
endmodule : wdcs_timed_access

// ### verilog/wdcs_top.sv
// watchdog control/status registers: flags, delayed reset, restart pulse, boot region select
`timescale 1ns/1ps
module wdcs_top (
  input wire logic clock,
  input wire logic resetn,
  input wire logic por_event,
  input wire logic pin_reset_event,
  input wire logic isp_reset_event,
  input wire logic wdt_timeout,
  input wire logic wdt_interrupt_enable,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic wdt_irq,
  output logic wdt_counter_restart,
  output logic sys_reset_req,
  output logic restart_from_loader,
  output logic [15:0] restart_vector
);
  logic unlocked;
  logic wr_boot;
  logic wr_ctl;
  logic prot_ok;
  logic pending_r;
  logic [9:0] delay_r;
  logic wdt_reset_fire;
  logic loader_r;
  logic por_flag_r;
  logic iflag_r;
  logic rflag_r;
  logic rena_r;
  logic restart_r;
  logic [7:0] ctl_view;

  assign wr_boot = sfr_wr && sfr_addr == wdcs_pkg::WDCS_BOOT_SELECT_ADDR;
  assign wr_ctl = sfr_wr && sfr_addr == wdcs_pkg::WDCS_CONTROL_STATUS_ADDR;
  assign prot_ok = unlocked;
  assign wdt_reset_fire = pending_r && delay_r == wdcs_pkg::WDCS_DELAY_LAST;

  // timed access unlock, closed by any write to a protected register
  wdcs_timed_access wdcs_timed_access_inst (
    .clock(clock),
    .resetn(resetn),
    .wr_en(sfr_wr),
    .wr_addr(sfr_addr),
    .wr_data(sfr_wdata),
    .consume(wr_boot || wr_ctl),
    .unlocked(unlocked)
  );

  // boot select bit, protected
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      loader_r <= 1'b0;
    end else if (por_event) begin
      loader_r <= 1'b0;
    end else if (wr_boot && prot_ok) begin
      loader_r <= sfr_wdata[wdcs_pkg::WDCS_BIT_LOADER];
    end
  end

  // power-on flag: hardware sets on power-up, software write clears
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      por_flag_r <= 1'b1;
    end else if (por_event) begin
      por_flag_r <= 1'b1;
    end else if (wr_ctl && prot_ok) begin
      por_flag_r <= sfr_wdata[wdcs_pkg::WDCS_BIT_POR];
    end
  end

  // interrupt flag: time-out sets, wins over a clear in the same cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      iflag_r <= 1'b0;
    end else if (por_event || pin_reset_event) begin
      iflag_r <= 1'b0;
    end else if (wdt_timeout) begin
      iflag_r <= 1'b1;
    end else if (wr_ctl && prot_ok) begin
      iflag_r <= sfr_wdata[wdcs_pkg::WDCS_BIT_IFLAG];
    end
  end

  // reset flag: set by watchdog reset, cleared by power-on or software
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rflag_r <= 1'b0;
    end else if (por_event) begin
      rflag_r <= 1'b0;
    end else if (wdt_reset_fire) begin
      rflag_r <= 1'b1;
    end else if (wr_ctl) begin // free write; pin reset leaves it alone
      rflag_r <= sfr_wdata[wdcs_pkg::WDCS_BIT_RFLAG];
    end
  end

  // reset enable: cleared by every reset source
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rena_r <= 1'b0;
    end else if (por_event || pin_reset_event || isp_reset_event || wdt_reset_fire) begin
      rena_r <= 1'b0;
    end else if (wr_ctl && prot_ok) begin
      rena_r <= sfr_wdata[wdcs_pkg::WDCS_BIT_RENA];
    end
  end

  // restart bit: one-cycle self-clearing pulse to the counter
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      restart_r <= 1'b0;
    end else begin
      restart_r <= wr_ctl && prot_ok && sfr_wdata[wdcs_pkg::WDCS_BIT_RESTART];
    end
  end

  // delay from time-out to system reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pending_r <= 1'b0;
      delay_r <= 10'h000;
    end else if (por_event || pin_reset_event || isp_reset_event || wdt_reset_fire) begin
      pending_r <= 1'b0;
      delay_r <= 10'h000;
    end else if (pending_r) begin
      delay_r <= delay_r + 10'h001;
    end else if (wdt_timeout && rena_r) begin
      pending_r <= 1'b1;
      delay_r <= 10'h000;
    end
  end

  // registered outputs
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wdt_irq <= 1'b0;
      sys_reset_req <= 1'b0;
      restart_vector <= 16'h0000;
    end else begin
      wdt_irq <= iflag_r && wdt_interrupt_enable;
      sys_reset_req <= wdt_reset_fire;
      restart_vector <= wdcs_pkg::WDCS_RESTART_VECTOR;
    end
  end

  assign wdt_counter_restart = restart_r;
  assign restart_from_loader = loader_r;

  // read view; reserved bits read zero
  always_comb begin
    ctl_view = 8'h00;
    ctl_view[wdcs_pkg::WDCS_BIT_POR] = por_flag_r;
    ctl_view[wdcs_pkg::WDCS_BIT_IFLAG] = iflag_r;
    ctl_view[wdcs_pkg::WDCS_BIT_RFLAG] = rflag_r;
    ctl_view[wdcs_pkg::WDCS_BIT_RENA] = rena_r;
    ctl_view[wdcs_pkg::WDCS_BIT_RESTART] = restart_r;
  end

  // registered read data
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd && sfr_addr == wdcs_pkg::WDCS_CONTROL_STATUS_ADDR) begin
      sfr_rdata <= ctl_view;
    end else if (sfr_rd && sfr_addr == wdcs_pkg::WDCS_BOOT_SELECT_ADDR) begin
      sfr_rdata <= {7'h00, loader_r};
    end else if (sfr_rd) begin
      sfr_rdata <= 8'h00;
    end
  end

  // helper: cycles since an armed time-out, kept apart from the delay counter
  logic arm_seen_r;
  logic [10:0] since_arm_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      arm_seen_r <= 1'b0;
      since_arm_r <= 11'h000;
    end else if (por_event || pin_reset_event || isp_reset_event || sys_reset_req) begin
      arm_seen_r <= 1'b0;
      since_arm_r <= 11'h000;
    end else if (wdt_timeout && rena_r && !pending_r) begin
      arm_seen_r <= 1'b1;
      since_arm_r <= 11'h000;
    end else if (arm_seen_r) begin
      since_arm_r <= since_arm_r + 11'h001;
    end
  end

  // key writes as seen on the register bus
  logic key1_now;
  logic key2_now;
  assign key1_now = sfr_wr && sfr_addr == wdcs_pkg::WDCS_TA_KEY_ADDR
    && sfr_wdata == wdcs_pkg::WDCS_TA_KEY1;
  assign key2_now = sfr_wr && sfr_addr == wdcs_pkg::WDCS_TA_KEY_ADDR
    && sfr_wdata == wdcs_pkg::WDCS_TA_KEY2;

  // unlock steps: a fresh first key while locked, then the second key
  sequence s_key_pair;
    !key1_now ##1 (key1_now && !unlocked) ##1 key2_now;
  endsequence
  // restart write straight after the key pair
  sequence s_unlocked_restart;
    s_key_pair ##1 (wr_ctl && sfr_wdata[wdcs_pkg::WDCS_BIT_RESTART]);
  endsequence

  // armed time-out keeps the delay running
  a_reset_delay: assert property (@(posedge clock) disable iff (!resetn)
    (wdt_timeout && rena_r && !pending_r && !por_event && !pin_reset_event && !isp_reset_event)
    |=> pending_r [*8]) else $error("reset delay not running");
  // fire only at the last delay count
  a_fire_count: assert property (@(posedge clock) disable iff (!resetn)
    wdt_reset_fire |-> pending_r && delay_r == wdcs_pkg::WDCS_DELAY_LAST)
    else $error("reset fired early");
  // request lands exactly the documented delay after the time-out
  a_reset_exact: assert property (@(posedge clock) disable iff (!resetn)
    sys_reset_req |-> arm_seen_r && since_arm_r == 11'(wdcs_pkg::WDCS_RESET_DELAY_CLK))
    else $error("reset request off its delay");
  // time-out sets the interrupt flag
  a_iflag_set: assert property (@(posedge clock) disable iff (!resetn)
    (wdt_timeout && !por_event && !pin_reset_event) |=> iflag_r)
    else $error("flag not set");
  // flag stays until an unlocked write or a power-on or pin reset clears it
  a_iflag_hold: assert property (@(posedge clock) disable iff (!resetn)
    (iflag_r && !por_event && !pin_reset_event && !(wr_ctl && unlocked)) |=> iflag_r)
    else $error("interrupt flag dropped");
  // interrupt follows flag and enable
  a_irq_out: assert property (@(posedge clock) disable iff (!resetn)
    (iflag_r && wdt_interrupt_enable) |=> wdt_irq)
    else $error("irq missing");
  // locked writes leave protected bits alone
  a_locked_ignore: assert property (@(posedge clock) disable iff (!resetn)
    (wr_ctl && !unlocked && !por_event && !pin_reset_event && !isp_reset_event && !wdt_timeout
     && !wdt_reset_fire) |=> $stable(rena_r) && $stable(iflag_r)) else $error("lock bypass");
  // locked write leaves the power-on flag alone
  a_por_locked: assert property (@(posedge clock) disable iff (!resetn)
    (wr_ctl && !unlocked && !por_event) |=> $stable(por_flag_r))
    else $error("power-on flag written while locked");
  // locked boot select write ignored
  a_boot_locked: assert property (@(posedge clock) disable iff (!resetn)
    (wr_boot && !unlocked && !por_event) |=> $stable(loader_r))
    else $error("boot lock");
  // unlocked boot select write reaches the region select output
  a_boot_output: assert property (@(posedge clock) disable iff (!resetn)
    (wr_boot && unlocked && !por_event)
    |=> restart_from_loader == $past(sfr_wdata[wdcs_pkg::WDCS_BIT_LOADER]))
    else $error("boot select not applied");
  // power-on state of the flags
  a_por_set: assert property (@(posedge clock) disable iff (!resetn)
    por_event |=> por_flag_r && !rflag_r && !rena_r)
    else $error("power-on state");
  // restart bit is a one-cycle pulse
  a_restart_pulse: assert property (@(posedge clock) disable iff (!resetn)
    restart_r |=> !restart_r || $past(wr_ctl))
    else $error("restart stuck");
  // restart after a key pair gives exactly one pulse
  a_restart_unlocked: assert property (@(posedge clock) disable iff (!resetn)
    s_unlocked_restart |=> wdt_counter_restart ##1 !wdt_counter_restart)
    else $error("restart pulse after unlock wrong");
  // key pair opens the window
  a_unlock_open: assert property (@(posedge clock) disable iff (!resetn)
    s_key_pair |=> unlocked)
    else $error("key pair did not unlock");
  // window shuts after its four cycles
  a_window_close: assert property (@(posedge clock) disable iff (!resetn)
    s_key_pair |-> ##5 !unlocked)
    else $error("unlock window too long");
  // a protected write uses up the window
  a_window_used: assert property (@(posedge clock) disable iff (!resetn)
    (wr_boot || wr_ctl) |=> !unlocked)
    else $error("window not closed by write");
  // pin reset keeps the reset flag
  a_pin_keep: assert property (@(posedge clock) disable iff (!resetn)
    (pin_reset_event && !por_event && !wdt_reset_fire && !wr_ctl) |=> $stable(rflag_r))
    else $error("pin reset changed flag");
  // pin reset clears flag, enable and pending delay
  a_pin_clear: assert property (@(posedge clock) disable iff (!resetn)
    (pin_reset_event && !por_event) |=> !iflag_r && !rena_r && !pending_r)
    else $error("pin reset state wrong");
  // programming reset clears enable and pending delay
  a_isp_clear: assert property (@(posedge clock) disable iff (!resetn)
    isp_reset_event |=> !rena_r && !pending_r)
    else $error("programming reset state wrong");
  // watchdog reset sets the reset flag and drops the enable
  a_fire_flags: assert property (@(posedge clock) disable iff (!resetn)
    (wdt_reset_fire && !por_event) |=> rflag_r && !rena_r)
    else $error("watchdog reset flags wrong");
  // read of the control/status register returns its bits
  a_read_view: assert property (@(posedge clock) disable iff (!resetn)
    (sfr_rd && sfr_addr == wdcs_pkg::WDCS_CONTROL_STATUS_ADDR) |=> sfr_rdata == $past(ctl_view))
    else $error("read data wrong");
endmodule : wdcs_top

// ### tb/watchdog_control_status_bench.sv
// bench for the watchdog control/status block, register reads scored through a queue
`timescale 1ns/1ps
module watchdog_control_status_bench;
  localparam logic [7:0] CS = wdcs_pkg::WDCS_CONTROL_STATUS_ADDR;
  localparam logic [7:0] BS = wdcs_pkg::WDCS_BOOT_SELECT_ADDR;
  logic clock, resetn, por_event, pin_reset_event, isp_reset_event, wdt_timeout;
  logic wdt_interrupt_enable, sfr_wr, sfr_rd, pend;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, st, d;
  logic wdt_irq, wdt_counter_restart, sys_reset_req, restart_from_loader;
  logic [15:0] restart_vector;
  logic [7:0] exp_q[$];
  int err_count, compares, seed, n;

  wdcs_top wdcs_top_inst (.clock(clock), .resetn(resetn), .por_event(por_event),
    .pin_reset_event(pin_reset_event), .isp_reset_event(isp_reset_event),
    .wdt_timeout(wdt_timeout), .wdt_interrupt_enable(wdt_interrupt_enable),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .wdt_irq(wdt_irq), .wdt_counter_restart(wdt_counter_restart),
    .sys_reset_req(sys_reset_req), .restart_from_loader(restart_from_loader),
    .restart_vector(restart_vector));

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // read monitor: each returned byte against the oldest note
  always @(posedge clock) begin
    if (pend) begin
      if (exp_q.size() == 0) chk("read without note", 16'h1, 16'h0);
      else chk("read data", {8'h00, sfr_rdata}, {8'h00, exp_q.pop_front()});
    end
    pend <= sfr_rd;
  end

  // write strobe stays up across back-to-back calls; idle drops it
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= v;
  endtask : wr

  task automatic idle();
    @(posedge clock);
    sfr_wr <= 1'b0;
  endtask : idle

  // key pair then the protected write inside the open window
  task automatic twr(input logic [7:0] a, input logic [7:0] v);
    wr(wdcs_pkg::WDCS_TA_KEY_ADDR, wdcs_pkg::WDCS_TA_KEY1);
    wr(wdcs_pkg::WDCS_TA_KEY_ADDR, wdcs_pkg::WDCS_TA_KEY2);
    wr(a, v);
    idle();
  endtask : twr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    exp_q.push_back(e);
    @(posedge clock);
    sfr_rd <= 1'b0;
    @(posedge clock);
  endtask : rd

  // one-cycle event: 0 time-out, 1 programming, 2 pin, 3 power-on
  task automatic evt(input int k);
    @(posedge clock);
    {por_event, pin_reset_event, isp_reset_event, wdt_timeout} <= 4'h1 << k;
    @(posedge clock);
    {por_event, pin_reset_event, isp_reset_event, wdt_timeout} <= 4'h0;
  endtask : evt

  initial begin
    seed = 72821;
    {resetn, por_event, pin_reset_event, isp_reset_event, wdt_timeout} = 5'h00;
    {wdt_interrupt_enable, sfr_wr, sfr_rd} = 3'h0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    err_count = 0;
    compares = 0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    rd(CS, 8'h40);
    rd(BS, 8'h00);
    chk("vector", restart_vector, 16'h0000);
    $display("test reset state done");
    // plain writes reach bit 2 only
    wr(CS, 8'h4f);
    idle();
    #1;
    chk("restart without key", {15'h0, wdt_counter_restart}, 16'h0);
    rd(CS, 8'h44);
    wr(BS, 8'h01);
    idle();
    rd(BS, 8'h00);
    twr(BS, 8'h01);
    rd(BS, 8'h01);
    chk("loader", {15'h0, restart_from_loader}, 16'h1);
    twr(CS, 8'h03);
    #1;
    chk("restart", {15'h0, wdt_counter_restart}, 16'h1);
    @(posedge clock);
    #1;
    chk("restart end", {15'h0, wdt_counter_restart}, 16'h0);
    rd(CS, 8'h02);
    $display("test access protection done");
    // time-out with reset enabled
    wdt_interrupt_enable <= 1'b1;
    evt(0);
    n = 1;
    while (sys_reset_req !== 1'b1 && n < 600) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("reset delay", {15'h0, n >= 512 && n <= 516}, 16'h1);
    if (n >= 600) report_and_stop();
    chk("irq", {15'h0, wdt_irq}, 16'h1);
    rd(CS, 8'h0c);
    chk("vector", restart_vector, 16'h0000);
    wr(CS, 8'h00);
    idle();
    rd(CS, 8'h08);
    wdt_interrupt_enable <= 1'b0;
    repeat (3) @(posedge clock);
    chk("irq masked", {15'h0, wdt_irq}, 16'h0);
    twr(CS, 8'h00);
    rd(CS, 8'h00);
    $display("test time-out done");
    // pin and programming resets
    twr(CS, 8'h06);
    evt(2);
    rd(CS, 8'h04);
    twr(CS, 8'h02);
    evt(1);
    rd(CS, 8'h00);
    $display("test reset sources done");
    // random plain writes and unmapped reads
    st = 8'h00;
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      wr(CS, d);
      idle();
      st = (st & 8'hfb) | (d & 8'h04);
      rd(CS, st);
      rd({2'b00, d[5:0]}, 8'h00);
    end
    $display("test random writes done");
    evt(3);
    rd(CS, 8'h40);
    rd(BS, 8'h00);
    $display("test power-on done");
    repeat (4) @(posedge clock);
    report_and_stop();
  end
endmodule : watchdog_control_status_bench
